//--- testbench/bocs_mem_model.sv
// Core memory model answering sequencer requests with data release
`timescale 1ns/1ps
`include "bocs_map.svh"
module bocs_mem_model (
  // Clock
  input wire logic mclk_i,
  // Requests
  input wire logic data_request_flag_i,
  input wire logic [`BOCS_ADDR_W-1:0] mem_addr_i,
  // Behaviour control
  input wire logic [3:0] lat_i,
  input wire logic miss_en_i,
  input wire logic [`BOCS_ADDR_W-1:0] miss_addr_i,
  // Answer
  output logic data_release_o,
  output logic nonexist_o
);
  // ==========================================
  // Release one request after lat_i cycles
  logic [3:0] wait_ff;
  logic cool_ff;

  initial
  begin
    data_release_o = 1'b0;
    nonexist_o = 1'b0;
    wait_ff = 4'h0;
    cool_ff = 1'b0;
  end

  always @(posedge mclk_i)
  begin
    data_release_o <= 1'b0;
    // Qualifier is meaningless outside a release
    nonexist_o <= ~nonexist_o;
    if (data_release_o || cool_ff)
    begin
      // Let the flags settle before counting a new request
      cool_ff <= data_release_o;
      wait_ff <= 4'h0;
    end
    else if (data_request_flag_i)
    begin
      if (wait_ff == lat_i)
      begin
        data_release_o <= 1'b1;
        nonexist_o <= miss_en_i && (mem_addr_i == miss_addr_i);
      end
      else
      begin
        wait_ff <= wait_ff + 4'h1;
      end
    end
    else
    begin
      wait_ff <= 4'h0;
    end
  end
endmodule : bocs_mem_model

//--- testbench/branch_on_count_sequencer_tb_top.sv
// Testbench for the count-and-branch execution sequencer
`timescale 1ns/1ps
`include "bocs_map.svh"
`define CHK(nm, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
  end
module branch_on_count_sequencer_tb_top;
  logic mclk_i, reset_i, preparation_phases_done_i, data_release_i, nonexist_i, miss_en;
  logic [7:0] opcode_i;
  logic [3:0] lat;
  logic [31:0] reg_val_i, prog_addr_i, reg_wdata_o;
  logic [16:0] eff_addr_i, instr_addr_i, mem_addr_o, p_addr_o, trap_loc_o, saved_ia_o;
  logic memory_request_flag_o, data_request_flag_o, reg_wr_o, program_addr_in_p_flag_o;
  logic busy_o, end_of_instruction_functions_o, next_from_eff_o, trap_o;
  int miscompares, n_compared;

  // ==========================================
  // Design and memory
  bocs_seq dut (.mclk_i(mclk_i), .reset_i(reset_i), .preparation_phases_done_i(preparation_phases_done_i),
    .opcode_i(opcode_i), .reg_val_i(reg_val_i), .prog_addr_i(prog_addr_i),
    .eff_addr_i(eff_addr_i), .instr_addr_i(instr_addr_i), .data_release_i(data_release_i),
    .nonexist_i(nonexist_i), .memory_request_flag_o(memory_request_flag_o),
    .data_request_flag_o(data_request_flag_o), .mem_addr_o(mem_addr_o), .reg_wr_o(reg_wr_o),
    .reg_wdata_o(reg_wdata_o), .p_addr_o(p_addr_o),
    .program_addr_in_p_flag_o(program_addr_in_p_flag_o), .busy_o(busy_o),
    .end_of_instruction_functions_o(end_of_instruction_functions_o),
    .next_from_eff_o(next_from_eff_o), .trap_o(trap_o), .trap_loc_o(trap_loc_o),
    .saved_ia_o(saved_ia_o));
  bocs_mem_model mem (.mclk_i(mclk_i), .data_request_flag_i(data_request_flag_o),
    .mem_addr_i(mem_addr_o), .lat_i(lat), .miss_en_i(miss_en), .miss_addr_i(eff_addr_i),
    .data_release_o(data_release_i), .nonexist_o(nonexist_i));

  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  task conclude;
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // ==========================================
  // One instruction, judged from the rules
  task run_op(input logic [7:0] op, input logic [31:0] a, input logic [31:0] b,
              input logic [16:0] eff, input logic [16:0] ia, input logic miss,
              input logic [3:0] l);
    logic [31:0] res, first_wr, last_wr;
    logic taken, xtrap, done;
    int i;
    res = op[0] ? a + 32'h0000_0001 : a - 32'h0000_0001;
    taken = op[0] ? res[31] : (res != 32'h0000_0000 && !res[31]);
    xtrap = taken && miss;
    first_wr = 'x;
    last_wr = 'x;
    done = 1'b0;
    @(posedge mclk_i);
    lat <= l;
    miss_en <= miss;
    preparation_phases_done_i <= 1'b1;
    opcode_i <= op;
    reg_val_i <= a;
    prog_addr_i <= b;
    eff_addr_i <= eff;
    instr_addr_i <= ia;
    @(posedge mclk_i);
    preparation_phases_done_i <= 1'b0;
    #1;
    `CHK("mem_addr", eff, mem_addr_o)
    `CHK("mem_req", 1'b1, memory_request_flag_o)
    `CHK("data_req", 1'b1, data_request_flag_o)
    `CHK("busy", 1'b1, busy_o)
    for (i = 0; i < 60 && !done; i++)
    begin
      @(posedge mclk_i);
      #1;
      if (i == 0)
        `CHK("wr_strobe", 1'b1, reg_wr_o)
      if (reg_wr_o === 1'b1)
      begin
        if (i == 0)
          first_wr = reg_wdata_o;
        last_wr = reg_wdata_o;
      end
      done = (end_of_instruction_functions_o === 1'b1) || (trap_o === 1'b1);
    end
    if (!done)
    begin
      miscompares++;
      conclude();
    end
    `CHK("count", res, first_wr)
    `CHK("trap", xtrap, trap_o)
    `CHK("end_pulse", !xtrap, end_of_instruction_functions_o)
    if (xtrap)
    begin
      `CHK("restore", a, last_wr)
      `CHK("saved_ia", ia, saved_ia_o)
      `CHK("trap_loc", `BOCS_TRAP_LOC, trap_loc_o)
    end
    else
    begin
      `CHK("from_eff", taken, next_from_eff_o)
      if (!taken)
      begin
        `CHK("p_addr", b[16:0], p_addr_o)
        `CHK("in_p", 1'b1, program_addr_in_p_flag_o)
        `CHK("seq_addr", b[16:0], mem_addr_o)
      end
      else
      begin
        `CHK("p_eff", eff, p_addr_o)
        `CHK("in_p_clear", 1'b0, program_addr_in_p_flag_o)
      end
    end
    `CHK("drq_clear", 1'b0, data_request_flag_o)
    @(posedge mclk_i);
    #1;
    `CHK("idle", 1'b0, busy_o)
  endtask : run_op

  task down_cases;
    run_op(8'h64, 32'h0000_0005, 32'h0000_0101, 17'h0_0200, 17'h0_0100, 1'b0, 4'h0);
    run_op(8'hE4, 32'h0000_0001, 32'h0001_0104, 17'h0_0300, 17'h1_0103, 1'b0, 4'h5);
    run_op(8'h64, 32'h0000_0000, 32'h0000_0402, 17'h0_0500, 17'h0_0401, 1'b0, 4'h2);
    run_op(8'hE4, 32'h8000_0000, 32'h0000_0602, 17'h0_0700, 17'h0_0601, 1'b0, 4'h3);
  endtask : down_cases

  task up_cases;
    run_op(8'h65, 32'hFFFF_FFFE, 32'h0000_0802, 17'h0_0900, 17'h0_0801, 1'b0, 4'h0);
    run_op(8'hE5, 32'hFFFF_FFFF, 32'h0000_0A02, 17'h0_0B00, 17'h0_0A01, 1'b0, 4'h4);
    run_op(8'h65, 32'h7FFF_FFFF, 32'h0000_0C02, 17'h0_0D00, 17'h0_0C01, 1'b0, 4'h1);
    run_op(8'hE5, 32'h0000_0003, 32'h0000_0E02, 17'h0_0F00, 17'h0_0E01, 1'b0, 4'h0);
  endtask : up_cases

  task trap_cases;
    run_op(8'h64, 32'h0000_0005, 32'h0000_1002, 17'h1_1000, 17'h0_1001, 1'b1, 4'h0);
    run_op(8'hE5, 32'hFFFF_FFFE, 32'h0000_1202, 17'h1_1200, 17'h0_1201, 1'b1, 4'h3);
    run_op(8'h64, 32'h0000_0001, 32'h0000_1402, 17'h1_1400, 17'h0_1401, 1'b1, 4'h0);
    run_op(8'h65, 32'h0000_0010, 32'h0000_1602, 17'h1_1600, 17'h0_1601, 1'b1, 4'h2);
  endtask : trap_cases

  task refuse_other;
    @(posedge mclk_i);
    preparation_phases_done_i <= 1'b1;
    opcode_i <= 8'h66;
    @(posedge mclk_i);
    preparation_phases_done_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    `CHK("busy_other", 1'b0, busy_o)
    `CHK("req_other", 1'b0, memory_request_flag_o)
  endtask : refuse_other

  // Reset in mid-instruction returns to idle
  task reset_mid;
    @(posedge mclk_i);
    preparation_phases_done_i <= 1'b1;
    opcode_i <= 8'h64;
    reg_val_i <= 32'h0000_0009;
    lat <= 4'h8;
    miss_en <= 1'b0;
    @(posedge mclk_i);
    preparation_phases_done_i <= 1'b0;
    @(posedge mclk_i);
    reset_i <= 1'b1;
    @(posedge mclk_i);
    reset_i <= 1'b0;
    #1;
    `CHK("rst_busy", 1'b0, busy_o)
    `CHK("rst_drq", 1'b0, data_request_flag_o)
    `CHK("rst_wr", 1'b0, reg_wr_o)
  endtask : reset_mid

  // ==========================================
  // Main sequence
  initial
  begin
    miscompares = 0;
    n_compared = 0;
    reset_i = 1'b1;
    preparation_phases_done_i = 1'b0;
    opcode_i = 8'h00;
    reg_val_i = 32'h0000_0000;
    prog_addr_i = 32'h0000_0000;
    eff_addr_i = 17'h0_0000;
    instr_addr_i = 17'h0_0000;
    lat = 4'h0;
    miss_en = 1'b0;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    #1;
    `CHK("reset_busy", 1'b0, busy_o)
    `CHK("reset_trap_loc", 17'h0_0000, trap_loc_o)
    down_cases();
    up_cases();
    refuse_other();
    trap_cases();
    reset_mid();
    down_cases();
    conclude();
  end
endmodule : branch_on_count_sequencer_tb_top

//--- verilog/bocs_count_unit.sv
// Preset adder forming A minus one or A plus one, with sum tests
`timescale 1ns/1ps
`include "bocs_map.svh"
module bocs_count_unit #(
  parameter int WIDTH = `BOCS_DATA_W
) (
  // Operand and preset
  input wire logic [WIDTH-1:0] a_i,
  input wire bocs_pkg::bocs_adder_t mode_i,
  // Sum and tests
  output logic [WIDTH-1:0] sum_o,
  output logic gtz_o,
  output logic neg_o
);
  import bocs_pkg::*;

  initial
  begin
    if (WIDTH < 2)
    begin
      $error("bocs_count_unit: WIDTH must be at least 2");
    end
  end

  always_comb
  begin
    case (mode_i)
      BOCS_ADD_MINUS1: sum_o = a_i - WIDTH'(1);
      BOCS_ADD_PLUS1: sum_o = a_i + WIDTH'(1);
      default: sum_o = a_i;
    endcase
  end

  // Sign is the top bit
  assign neg_o = sum_o[WIDTH-1];
  assign gtz_o = (|sum_o) & ~sum_o[WIDTH-1];

endmodule : bocs_count_unit

//--- verilog/bocs_map.svh
// Constants for the count-and-branch execution sequencer
`ifndef BOCS_MAP_SVH
`define BOCS_MAP_SVH

`define BOCS_DATA_W 32
`define BOCS_ADDR_W 17
`define BOCS_OPU_COUNT 3'h6
`define BOCS_OPL_DOWN 4'h4
`define BOCS_OPL_UP 4'h5
`define BOCS_TRAP_LOC 17'h0_0040
`define BOCS_WORD_RST 32'h0000_0000
`define BOCS_ADDR_RST 17'h0_0000

`endif

//--- verilog/bocs_pkg.sv
// Types for the count-and-branch execution sequencer
package bocs_pkg;

  typedef enum logic [1:0]
  {
    BOCS_IDLE = 2'b00,
    BOCS_FIRST = 2'b01,
    BOCS_SEQ_FETCH = 2'b10,
    BOCS_FINAL = 2'b11
  } bocs_phase_t;

  typedef enum logic [1:0]
  {
    BOCS_ADD_NONE = 2'b00,
    BOCS_ADD_MINUS1 = 2'b01,
    BOCS_ADD_PLUS1 = 2'b10
  } bocs_adder_t;

endpackage : bocs_pkg

//--- verilog/bocs_req_flags.sv
// Memory request and data request flags, cleared by data release
`timescale 1ns/1ps
module bocs_req_flags (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Control
  input wire logic set_i,
  input wire logic data_release_i,
  // Flags
  output logic mem_req_o,
  output logic data_req_o
);

  // Set wins over a release in the same cycle
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      mem_req_o <= 1'b0;
    end
    else if (set_i)
    begin
      mem_req_o <= 1'b1;
    end
    else if (data_release_i)
    begin
      mem_req_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      data_req_o <= 1'b0;
    end
    else if (set_i)
    begin
      data_req_o <= 1'b1;
    end
    else if (data_release_i)
    begin
      data_req_o <= 1'b0;
    end
  end

endmodule : bocs_req_flags

//--- verilog/bocs_seq.sv
// Execution sequencer for the count-down and count-up branch instructions
`timescale 1ns/1ps
`include "bocs_map.svh"
module bocs_seq #(
  parameter int DATA_W = `BOCS_DATA_W,
  parameter int ADDR_W = `BOCS_ADDR_W
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // End of preparation
  input wire logic preparation_phases_done_i,
  input wire logic [7:0] opcode_i,
  input wire logic [DATA_W-1:0] reg_val_i,
  input wire logic [DATA_W-1:0] prog_addr_i,
  input wire logic [ADDR_W-1:0] eff_addr_i,
  input wire logic [ADDR_W-1:0] instr_addr_i,
  // Core memory
  input wire logic data_release_i,
  input wire logic nonexist_i,
  output logic memory_request_flag_o,
  output logic data_request_flag_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  // Private memory write-back
  output logic reg_wr_o,
  output logic [DATA_W-1:0] reg_wdata_o,
  // Program address and end of instruction
  output logic [ADDR_W-1:0] p_addr_o,
  output logic program_addr_in_p_flag_o,
  output logic busy_o,
  output logic end_of_instruction_functions_o,
  output logic next_from_eff_o,
  // Trap
  output logic trap_o,
  output logic [ADDR_W-1:0] trap_loc_o,
  output logic [ADDR_W-1:0] saved_ia_o
);
  import bocs_pkg::*;

  initial
  begin
    if (DATA_W != `BOCS_DATA_W || ADDR_W != `BOCS_ADDR_W)
    begin
      $error("bocs_seq: only 32-bit data and 17-bit addresses supported");
    end
  end

  // ==========================================================
  // Decode and state
  // ==========================================================
  logic count_down_decode;
  logic count_up_decode;
  logic is_count;
  bocs_phase_t phase_ff;
  bocs_phase_t nxt_phase;
  logic [DATA_W-1:0] a_ff;
  logic [DATA_W-1:0] b_ff;
  logic [ADDR_W-1:0] ia_ff;
  bocs_adder_t adder_ff;
  logic wr_arm_ff;
  logic down_ff;
  logic bad_ea_ff;
  logic [DATA_W-1:0] sum;
  logic sum_greater_than_zero;
  logic sum_neg;
  logic goto_sequential_fetch;
  logic step_ok;
  logic bad_now;
  logic req_set;

  assign count_down_decode = (opcode_i[6:4] == `BOCS_OPU_COUNT)
                           && (opcode_i[3:0] == `BOCS_OPL_DOWN);
  assign count_up_decode = (opcode_i[6:4] == `BOCS_OPU_COUNT)
                         && (opcode_i[3:0] == `BOCS_OPL_UP);
  assign is_count = count_down_decode | count_up_decode;

  // Sequential-fetch and final phases do not advance while a data request waits for release
  assign step_ok = ~data_request_flag_o | data_release_i;

  // Effective-address fetch reported missing memory
  assign bad_now = bad_ea_ff
                 | (data_release_i & nonexist_i & data_request_flag_o
                    & ~program_addr_in_p_flag_o);

  // ==========================================================
  // Adder and branch condition
  // ==========================================================
  bocs_count_unit #(
    .WIDTH(DATA_W)
  ) u_count (
    .a_i(a_ff),
    .mode_i(adder_ff),
    .sum_o(sum),
    .gtz_o(sum_greater_than_zero),
    .neg_o(sum_neg)
  );

  always_comb
  begin
    if (down_ff)
    begin
      goto_sequential_fetch = ~sum_greater_than_zero;
    end
    else
    begin
      goto_sequential_fetch = ~sum_neg;
    end
  end

  // ==========================================================
  // Phase sequence
  // ==========================================================
  always_comb
  begin
    nxt_phase = phase_ff;
    case (phase_ff)
      BOCS_IDLE:
      begin
        if (preparation_phases_done_i && is_count)
        begin
          nxt_phase = BOCS_FIRST;
        end
      end
      BOCS_FIRST:
      begin
        // One clock only, never held
        nxt_phase = goto_sequential_fetch ? BOCS_SEQ_FETCH : BOCS_FINAL;
      end
      BOCS_SEQ_FETCH:
      begin
        if (step_ok)
        begin
          nxt_phase = BOCS_FINAL;
        end
      end
      BOCS_FINAL:
      begin
        if (step_ok)
        begin
          nxt_phase = BOCS_IDLE;
        end
      end
      default: nxt_phase = BOCS_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      phase_ff <= BOCS_IDLE;
    end
    else
    begin
      phase_ff <= nxt_phase;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      busy_o <= 1'b0;
    end
    else
    begin
      busy_o <= (nxt_phase != BOCS_IDLE);
    end
  end

  // ==========================================================
  // Operand capture at end of preparation
  // ==========================================================
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      a_ff <= `BOCS_WORD_RST;
      b_ff <= `BOCS_WORD_RST;
      ia_ff <= `BOCS_ADDR_RST;
      down_ff <= 1'b0;
      adder_ff <= BOCS_ADD_NONE;
      wr_arm_ff <= 1'b0;
    end
    else if (phase_ff == BOCS_IDLE && preparation_phases_done_i && is_count)
    begin
      a_ff <= reg_val_i;
      b_ff <= prog_addr_i;
      ia_ff <= instr_addr_i;
      down_ff <= count_down_decode;
      adder_ff <= count_down_decode ? BOCS_ADD_MINUS1 : BOCS_ADD_PLUS1;
      wr_arm_ff <= 1'b1;
    end
    else if (phase_ff == BOCS_FIRST)
    begin
      wr_arm_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Memory requests and program address
  // ==========================================================
  assign req_set = (phase_ff == BOCS_IDLE && preparation_phases_done_i && is_count)
                 || (phase_ff == BOCS_SEQ_FETCH && step_ok);

  bocs_req_flags u_req (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .set_i(req_set),
    .data_release_i(data_release_i),
    .mem_req_o(memory_request_flag_o),
    .data_req_o(data_request_flag_o)
  );

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      mem_addr_o <= `BOCS_ADDR_RST;
      p_addr_o <= `BOCS_ADDR_RST;
      program_addr_in_p_flag_o <= 1'b0;
    end
    else if (phase_ff == BOCS_IDLE && preparation_phases_done_i && is_count)
    begin
      mem_addr_o <= eff_addr_i;
      p_addr_o <= eff_addr_i;
      program_addr_in_p_flag_o <= 1'b0;
    end
    else if (phase_ff == BOCS_SEQ_FETCH && step_ok)
    begin
      // Fetched target word is discarded; sequential address taken from b_ff
      mem_addr_o <= b_ff[ADDR_W-1:0];
      p_addr_o <= b_ff[ADDR_W-1:0];
      program_addr_in_p_flag_o <= 1'b1;
    end
  end

  // Missing memory on the effective-address fetch
  always_ff @(posedge mclk_i)
  begin
    if (reset_i || (phase_ff == BOCS_IDLE))
    begin
      bad_ea_ff <= 1'b0;
    end
    else if (bad_now)
    begin
      bad_ea_ff <= 1'b1;
    end
  end

  // ==========================================================
  // Write-back, end of instruction and trap
  // ==========================================================
  logic trap_now;
  logic end_now;

  assign trap_now = (phase_ff == BOCS_FINAL) && step_ok
                  && ~program_addr_in_p_flag_o && bad_now;
  assign end_now = (phase_ff == BOCS_FINAL) && step_ok && ~trap_now;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      reg_wr_o <= 1'b0;
      reg_wdata_o <= `BOCS_WORD_RST;
    end
    else if (phase_ff == BOCS_FIRST && wr_arm_ff)
    begin
      reg_wr_o <= 1'b1;
      reg_wdata_o <= sum;
    end
    else if (trap_now)
    begin
      reg_wr_o <= 1'b1;
      reg_wdata_o <= a_ff;
    end
    else
    begin
      reg_wr_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      end_of_instruction_functions_o <= 1'b0;
      next_from_eff_o <= 1'b0;
    end
    else
    begin
      end_of_instruction_functions_o <= end_now;
      if (end_now)
      begin
        next_from_eff_o <= ~program_addr_in_p_flag_o;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      trap_o <= 1'b0;
      trap_loc_o <= `BOCS_ADDR_RST;
      saved_ia_o <= `BOCS_ADDR_RST;
    end
    else
    begin
      trap_o <= trap_now;
      if (trap_now)
      begin
        trap_loc_o <= `BOCS_TRAP_LOC;
        saved_ia_o <= ia_ff;
      end
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  a_first_one_clk: assert property (phase_ff == BOCS_FIRST |=> phase_ff != BOCS_FIRST)
    else $error("First phase lasted more than one clock");
  a_first_writes: assert property (phase_ff == BOCS_FIRST |=> reg_wr_o
    && reg_wdata_o == $past(sum))
    else $error("Count result not written back");
  a_down_taken: assert property (phase_ff == BOCS_FIRST && down_ff
    && a_ff > 32'h0000_0001 && a_ff <= 32'h8000_0000 |=> phase_ff == BOCS_FINAL)
    else $error("Count-down branch not taken");
  a_down_seq: assert property (phase_ff == BOCS_FIRST && down_ff
    && (a_ff < 32'h0000_0002 || a_ff > 32'h8000_0000)
    |=> phase_ff == BOCS_SEQ_FETCH)
    else $error("Count-down wrongly branched");
  a_up_choice: assert property (phase_ff == BOCS_FIRST && !down_ff
    |=> (phase_ff == BOCS_FINAL) == (a_ff >= 32'h7FFF_FFFF && a_ff != 32'hFFFF_FFFF))
    else $error("Count-up phase choice wrong");
  a_trap_restore: assert property (trap_o |-> reg_wr_o && reg_wdata_o == a_ff
    && saved_ia_o == ia_ff && trap_loc_o == `BOCS_TRAP_LOC)
    else $error("Trap did not restore register or save address");
  a_hold_release: assert property ((phase_ff == BOCS_SEQ_FETCH
    || phase_ff == BOCS_FINAL) && data_request_flag_o && !data_release_i
    |=> $stable(phase_ff) && !end_of_instruction_functions_o)
    else $error("Phase advanced without data release");
  a_seq_refetch: assert property (phase_ff == BOCS_SEQ_FETCH && step_ok
    |=> memory_request_flag_o && data_request_flag_o
    && program_addr_in_p_flag_o && p_addr_o == $past(b_ff[ADDR_W-1:0]))
    else $error("Sequential fetch did not reload P");
  a_preparation_phases_request: assert property (phase_ff == BOCS_IDLE && preparation_phases_done_i && is_count
    |=> memory_request_flag_o && data_request_flag_o
    && mem_addr_o == $past(eff_addr_i) ##1 reg_wr_o)
    else $error("Preparation request missing");
  a_end_source: assert property (end_of_instruction_functions_o
    |-> next_from_eff_o == !program_addr_in_p_flag_o && !trap_o)
    else $error("Next instruction source wrong");

  c_down_taken: cover property (phase_ff == BOCS_FIRST && down_ff
    ##1 phase_ff == BOCS_FINAL ##[1:20] end_of_instruction_functions_o);
  c_up_seq: cover property (phase_ff == BOCS_FIRST && !down_ff
    ##1 phase_ff == BOCS_SEQ_FETCH ##[1:40] end_of_instruction_functions_o);
  c_trap: cover property (trap_o);

endmodule : bocs_seq
